// File: tb_top.sv
// testbench: directed scenarios for the vectored interrupt unit
`timescale 1ns/100ps
module tb_top;
   import vin_pkg::*;
   localparam logic [PC_W-1:0] VECS [6] = '{VEC_EXT0, VEC_EXT1, VEC_T0, VEC_T1, VEC_SER,
                                          VEC_MULTI};
   logic            core_clk;
   logic            rst_n;
   vin_av_req_t     av;
   logic [31:0]     av_readdata;
   logic            av_waitrequest;
   vin_core_in_t    core_in;
   vin_core_out_t   core_out;
   vin_src_evt_t    src_evt;
   logic [1:0]      pin;
   logic            periph_irq_pin;
   logic [1:0]      port_d_direction;
   logic [1:0]      port_pullup_sel;
   logic [1:0]      pullup_en;
   logic            cfg_filter_bypass;
   logic            cfg_periph_pin_sel;
   logic            rti_req;
   logic [PC_W-1:0] spc_pc;
   logic [1:0]      depth;
   int              n_fail;
   int              check_count;

   // ==========================================================
   // design and core model
   vin_unit dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .av(av), .av_readdata(av_readdata),
      .av_waitrequest(av_waitrequest), .core_in(core_in), .core_out(core_out),
      .src_evt(src_evt), .ext_irq_pin_0(pin[0]), .ext_irq_pin_1(pin[1]),
      .periph_irq_pin(periph_irq_pin), .port_d_direction(port_d_direction),
      .port_pullup_sel(port_pullup_sel), .pullup_en(pullup_en),
      .cfg_filter_bypass(cfg_filter_bypass), .cfg_periph_pin_sel(cfg_periph_pin_sel)
   );
   vin_core_model #(.DEPTH(2)) core_u (
      .core_clk(core_clk), .rst_n(rst_n), .core_out(core_out), .rti_req(rti_req),
      .core_in(core_in), .spc_pc_q(spc_pc), .depth_q(depth)
   );
   always #12.5 core_clk = ~core_clk;

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // avalon access: request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      rd = '0;
      // one idle edge keeps the release and the next request apart
      @(posedge core_clk);
      av <= '{read: !w, write: w, address: a, writedata: wd, byteenable: 4'hF};
      while (!done) begin
         @(posedge core_clk);
         n++;
         if (av_waitrequest === 1'b0) begin
            done = 1'b1;
            rd = av_readdata;
         end else if (n > 20) begin
            n_fail++;
            done = 1'b1;
         end
      end
      av.read <= 1'b0;
      av.write <= 1'b0;
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      chk(d, e);
   endtask
   task automatic pulse(input logic [6:0] e);
      src_evt <= vin_src_evt_t'(e);
      @(posedge core_clk);
      src_evt <= '0;
   endtask
   task automatic settle();
      repeat (12) @(posedge core_clk);
   endtask
   // waits for an accept and checks vector and pushed pc
   task automatic wait_take(input logic [PC_W-1:0] vec);
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (core_out.take !== 1'b1 && n < 40);
      chk(core_out.take, 1'b1);
      chk(core_out.push, 1'b1);
      chk(core_out.vector, vec);
      chk(core_out.push_pc, spc_pc);
      @(posedge core_clk);
   endtask
   task automatic idle_chk();
      int seen;
      seen = 0;
      repeat (16) begin
         @(negedge core_clk);
         if (core_out.take !== 1'b0) seen++;
      end
      chk(seen, 0);
      @(posedge core_clk);
   endtask
   task automatic do_rti();
      rti_req <= 1'b1;
      @(posedge core_clk);
      rti_req <= 1'b0;
      @(negedge core_clk);
      chk(core_out.pop, 1'b1);
      @(posedge core_clk);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_regs();
      rd_chk(OFS_CTRL0, 32'h0);
      rd_chk(OFS_CTRL1, 32'h0);
      rd_chk(OFS_MULTI, 32'h0);
      rd_chk(OFS_EDGE, 32'h0);
      wr(5'h14, 32'hFFFF_FFFF);
      rd_chk(5'h14, 32'h0);
      wr(OFS_EDGE, 32'h0000_000F);
      rd_chk(OFS_EDGE, 32'h0000_000F);
      wr(OFS_EDGE, 32'h0);
   endtask
   // all six flags pending: served one by one in fixed order
   task automatic t_priority();
      wr(OFS_CTRL1, 32'h3F);
      for (int i = 0; i < 6; i++) begin
         wr(OFS_CTRL0, 32'h7F);
         wait_take(VECS[i]);
         rd_chk(OFS_CTRL1, (32'h3E << i) & 32'h3F);
         rd_chk(OFS_CTRL0, 32'h7E);
         do_rti();
      end
   endtask
   task automatic t_gate();
      wr(OFS_CTRL0, 32'h08);
      pulse(7'h40);
      idle_chk();
      rd_chk(OFS_CTRL1, 32'h04);
      wr(OFS_CTRL0, 32'h09);
      wait_take(VEC_T0);
      do_rti();
      wr(OFS_CTRL0, 32'h09);
      pulse(7'h20);
      idle_chk();
      wr(OFS_CTRL0, 32'h11);
      wait_take(VEC_T1);
      do_rti();
   endtask
   task automatic t_stack();
      for (int i = 0; i < 3; i++) begin
         wr(OFS_CTRL0, 32'h21);
         pulse(7'h10);
         if (i < 2) wait_take(VEC_SER);
      end
      idle_chk();
      chk(depth, 2'h2);
      do_rti();
      wait_take(VEC_SER);
      do_rti();
      do_rti();
      @(negedge core_clk);
      chk(depth, 2'h0);
      @(posedge core_clk);
   endtask
   // software clear lands on the same edge as a new event
   task automatic t_race();
      logic [31:0] d;
      pulse(7'h40);
      fork
         bus(1'b1, OFS_CTRL1, 32'h0, d);
         begin
            // the event meets the edge at which the clear lands
            @(posedge core_clk);
            @(posedge core_clk);
            src_evt <= vin_src_evt_t'(7'h40);
            @(posedge core_clk);
            src_evt <= '0;
         end
      join
      rd_chk(OFS_CTRL1, 32'h04);
      wr(OFS_CTRL1, 32'h0);
   endtask
   task automatic t_edges();
      logic [1:0] c;
      wr(OFS_CTRL0, 32'h06);
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         wr(OFS_EDGE, {28'h0, c, c});
         pin <= 2'b11;
         settle();
         rd_chk(OFS_CTRL1, {30'h0, {2{c[0]}}});
         wr(OFS_CTRL1, 32'h0);
         pin <= 2'b00;
         settle();
         rd_chk(OFS_CTRL1, {30'h0, {2{c[1]}}});
         wr(OFS_CTRL1, 32'h0);
      end
      port_d_direction <= 2'b01;
      pin <= 2'b11;
      settle();
      rd_chk(OFS_CTRL1, 32'h1);
      wr(OFS_CTRL1, 32'h0);
      port_d_direction <= 2'b11;
      // a one-cycle spike is dropped by the filter, kept when bypassed
      for (int b = 0; b < 2; b++) begin
         cfg_filter_bypass <= b[0];
         pin <= 2'b10;
         @(posedge core_clk);
         pin <= 2'b11;
         settle();
         rd_chk(OFS_CTRL1, {31'h0, b[0]});
         wr(OFS_CTRL1, 32'h0);
      end
   endtask
   task automatic t_pullup();
      port_pullup_sel <= 2'b11;
      @(posedge core_clk);
      @(negedge core_clk);
      chk(pullup_en, 2'b11);
      @(posedge core_clk);
   endtask
   task automatic t_periph();
      wr(OFS_MULTI, 32'h1F);
      periph_irq_pin <= 1'b0;
      settle();
      rd_chk(OFS_MULTI, 32'h1F);
      periph_irq_pin <= 1'b1;
      cfg_periph_pin_sel <= 1'b1;
      settle();
      rd_chk(OFS_MULTI, 32'h1F);
      periph_irq_pin <= 1'b0;
      settle();
      rd_chk(OFS_MULTI, 32'h081F);
      rd_chk(OFS_CTRL1, 32'h20);
      wr(OFS_CTRL0, 32'h41);
      wait_take(VEC_MULTI);
      rd_chk(OFS_CTRL1, 32'h0);
      rd_chk(OFS_MULTI, 32'h081F);
      do_rti();
      wr(OFS_MULTI, 32'h1F);
      pulse(7'h0F);
      rd_chk(OFS_MULTI, 32'h171F);
      rd_chk(OFS_CTRL1, 32'h20);
   endtask

   // ==========================================================
   // verdict, main sequence and watchdog
   task automatic give_verdict();
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      av = '0;
      src_evt = '0;
      pin = 2'b00;
      periph_irq_pin = 1'b1;
      port_d_direction = 2'b11;
      port_pullup_sel = 2'b00;
      cfg_filter_bypass = 1'b0;
      cfg_periph_pin_sel = 1'b0;
      rti_req = 1'b0;
      n_fail = 0;
      check_count = 0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_priority();
      t_gate();
      t_stack();
      t_race();
      t_edges();
      t_pullup();
      t_periph();
      give_verdict();
   end
   // the tests need some 600 cycles; a hang is cut at 20000
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      give_verdict();
   end
endmodule

// File: vin_core_model.sv
// partner: core sequencer and hardware stack facing the interrupt unit
`timescale 1ns/100ps
module vin_core_model #(
   parameter int DEPTH = 2
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire vin_pkg::vin_core_out_t core_out,
   input  wire logic                   rti_req,
   output vin_pkg::vin_core_in_t       core_in,
   output logic [vin_pkg::PC_W-1:0]    spc_pc_q,
   output logic [1:0]                  depth_q
);
   import vin_pkg::*;
   logic [1:0]      ph_q;
   logic [PC_W-1:0] pc_q;

   // ==========================================================
   // instruction cycle
   // four clocks per instruction; the sampling strobe sits on the last one
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ph_q     <= 2'h0;
         pc_q     <= 13'h0100;
         spc_pc_q <= 13'h0000;
      end else begin
         ph_q <= ph_q + 2'h1;
         if (ph_q == 2'h3) begin
            pc_q     <= pc_q + 13'h0001;
            spc_pc_q <= pc_q;
         end
      end
   end

   // ==========================================================
   // stack depth
   // push on accept, pop on return; a full stack is reported to the unit
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         depth_q <= 2'h0;
      end else if (core_out.push && depth_q < DEPTH) begin
         depth_q <= depth_q + 2'h1;
      end else if (core_out.pop && depth_q != 2'h0) begin
         depth_q <= depth_q - 2'h1;
      end
   end

   // strobe, return pulse, full level and next pc towards the unit
   assign core_in = '{second_phase_clock: ph_q == 2'h3, return_from_interrupt: rti_req,
                      stack_full: depth_q == DEPTH, next_pc: pc_q};
endmodule

// File: vin_pkg.sv
// package: constants, types and register map of the vectored interrupt unit
//
// Behaviour
// - each source event sets its own request flag
// - each interrupt has its own enable bit; only enabled requests are taken
// - with global enable clear no interrupt is taken
// - on accept, push next pc, load source vector, fetch from vector
// - return from interrupt pops the saved pc from the stack
// - entering a service routine clears global enable automatically
// - requests during global disable still set and hold their flags
// - no request is acknowledged while the stack is full
// - requests are sampled and serviced on second phase clock pulses
// - fixed priority: ext0, ext1, counter0, counter1, serial, multi group
// - counter 0 vectors to 0CH, counter 1 to 10H
// - converter, clock, time base, peripheral pin share vector 18H and group flag
// - servicing the group vector clears only the group flag
// - external line flag set only on selected transition type
// - edge select: rising, falling, both or disabled per line
// - ext lines vector 04H and 08H; service clears line flag and global enable
// - external pin works only with its enable set and port bit an input
// - pull-high selection stays active while pin is an interrupt input
// - spike filter on ext lines, bypassed by one shared option
// - peripheral pin sets its flag on a falling transition
// - peripheral pin function chosen by fixed configuration option
// - any member source request sets the group flag (the code sets it only for members enabled in multi_group_control)
package vin_pkg;
   // ==========================================================
   // timing
   localparam int CLK_NS   = 25;
   localparam int FILT_NS  = 75;
   localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
   localparam int FILT_W   = 2;

   // ==========================================================
   // widths and source indices (priority order, index 0 highest)
   localparam int PC_W   = 13;
   localparam int N_SRC  = 6;
   localparam int N_MEM  = 5;
   localparam int IX_W   = 3;
   localparam logic [IX_W-1:0] IX_EXT0  = 3'h0;
   localparam logic [IX_W-1:0] IX_EXT1  = 3'h1;
   localparam logic [IX_W-1:0] IX_T0    = 3'h2;
   localparam logic [IX_W-1:0] IX_T1    = 3'h3;
   localparam logic [IX_W-1:0] IX_SER   = 3'h4;
   localparam logic [IX_W-1:0] IX_MULTI = 3'h5;
   // group members
   localparam int M_ADC = 0;
   localparam int M_RTC = 1;
   localparam int M_TB  = 2;
   localparam int M_PER = 3;
   localparam int M_T2  = 4;

   // ==========================================================
   // vectors
   localparam logic [PC_W-1:0] VEC_EXT0  = 13'h0004;
   localparam logic [PC_W-1:0] VEC_EXT1  = 13'h0008;
   localparam logic [PC_W-1:0] VEC_T0    = 13'h000C;
   localparam logic [PC_W-1:0] VEC_T1    = 13'h0010;
   localparam logic [PC_W-1:0] VEC_SER   = 13'h0014;
   localparam logic [PC_W-1:0] VEC_MULTI = 13'h0018;

   // ==========================================================
   // edge select codes
   localparam logic [1:0] EDGE_OFF  = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // ==========================================================
   // register map (byte addresses) and fields
   localparam int AW = 5;
   localparam logic [AW-1:0] OFS_CTRL0  = 5'h00; // irq_control_0
   localparam logic [AW-1:0] OFS_CTRL1  = 5'h04; // irq_control_1
   localparam logic [AW-1:0] OFS_MULTI  = 5'h08; // multi_group_control
   localparam logic [AW-1:0] OFS_EDGE   = 5'h0C; // edge_select_control
   localparam logic [AW-1:0] OFS_STATUS = 5'h10;
   localparam int F_GIE     = 0;
   localparam int F_EN_LSB  = 1;
   localparam int F_MFL_LSB = 8;
   localparam int F_VEC_LSB = 8;
   localparam int F_STK     = 0;
   localparam int F_SERV    = 1;

   // ==========================================================
   // types
   typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} vin_bus_st_t;

   typedef struct packed {
      logic          read;
      logic          write;
      logic [AW-1:0] address;
      logic [31:0]   writedata;
      logic [3:0]    byteenable;
   } vin_av_req_t;

   typedef struct packed {
      logic            second_phase_clock;
      logic            return_from_interrupt;
      logic            stack_full;
      logic [PC_W-1:0] next_pc;
   } vin_core_in_t;

   typedef struct packed {
      logic            take;
      logic            push;
      logic            pop;
      logic [PC_W-1:0] push_pc;
      logic [PC_W-1:0] vector;
   } vin_core_out_t;

   typedef struct packed {
      logic t0_ovf;
      logic t1_ovf;
      logic serial_done;
      logic adc_done;
      logic rtc_ovf;
      logic tbase_ovf;
      logic t2_ovf;
   } vin_src_evt_t;
endpackage

// File: vin_unit.sv
// design: vectored interrupt unit with avalon-mm register slave
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module vin_unit (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire vin_pkg::vin_av_req_t   av,
   output logic [31:0]                 av_readdata,
   output logic                        av_waitrequest,
   input  wire vin_pkg::vin_core_in_t  core_in,
   output vin_pkg::vin_core_out_t      core_out,
   input  wire vin_pkg::vin_src_evt_t  src_evt,
   input  wire logic                   ext_irq_pin_0,
   input  wire logic                   ext_irq_pin_1,
   input  wire logic                   periph_irq_pin,
   input  wire logic [1:0]             port_d_direction,
   input  wire logic [1:0]             port_pullup_sel,
   output logic [1:0]                  pullup_en,
   input  wire logic                   cfg_filter_bypass,
   input  wire logic                   cfg_periph_pin_sel
);
   import vin_pkg::*;

   // ==========================================================
   // functions
   // lowest set index wins
   function automatic logic [IX_W-1:0] first_set(input logic [N_SRC-1:0] p);
      logic [IX_W-1:0] r;
      r = IX_MULTI;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (p[i]) begin
            r = IX_W'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [PC_W-1:0] vec_of(input logic [IX_W-1:0] ix);
      logic [PC_W-1:0] v;
      case (ix)
         IX_EXT0: v = VEC_EXT0;
         IX_EXT1: v = VEC_EXT1;
         IX_T0:   v = VEC_T0;
         IX_T1:   v = VEC_T1;
         IX_SER:  v = VEC_SER;
         default: v = VEC_MULTI;
      endcase
      return v;
   endfunction

   // ==========================================================
   // state
   vin_bus_st_t       bus_q;
   logic              gie_q;
   logic [N_SRC-1:0]  en_q;
   logic [N_SRC-1:0]  flags_q;
   logic [N_SRC-1:0]  flags_base;
   logic [N_SRC-1:0]  svc_clr;
   logic [N_MEM-1:0]  men_q;
   logic [N_MEM-1:0]  mflag_q;
   logic [3:0]        edge_q;
   logic [PC_W-1:0]   last_vec_q;
   logic [31:0]       rdata_q;
   vin_core_out_t     cout_q;
   logic [1:0]        pull_q;
   logic [1:0]        ext_edge;
   logic [2:0]        per_sync_q;
   logic              per_fall;
   logic [N_SRC-1:0]  evt;
   logic [N_MEM-1:0]  mevt;
   logic [N_SRC-1:0]  pend;
   logic [IX_W-1:0]   grant;
   logic              take;
   logic              acc;
   logic              wr_ok;
   logic              wr0;
   logic              wr1;
   logic              wr_m;
   logic              wr_e;

   // ==========================================================
   // external lines: sync, spike filter, edge select
   generate
      for (genvar g = 0; g < 2; g++) begin : g_ext
         logic              s1_q;
         logic              s2_q;
         logic              lvl_q;
         logic              prev_q;
         logic [FILT_W-1:0] cnt_q;
         logic [1:0]        sel;
         logic              pin;
         assign pin = (g == 0) ? ext_irq_pin_0 : ext_irq_pin_1;
         assign sel = edge_q[2*g +: 2];
         // two flop synchroniser
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
            end else begin
               s1_q <= pin;
               s2_q <= s1_q;
            end
         end
         // level must hold for the filter time unless bypassed
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               lvl_q <= 1'b0;
               prev_q <= 1'b0;
               cnt_q <= '0;
            end else begin
               prev_q <= lvl_q;
               if (cfg_filter_bypass || s2_q == lvl_q) begin
                  lvl_q <= s2_q;
                  cnt_q <= '0;
               end else if (cnt_q == FILT_W'(FILT_CYC - 1)) begin
                  lvl_q <= s2_q;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         end
         // edge on the synchronised level, gated by enable and port input
         always_comb begin
            ext_edge[g] = 1'b0;
            if (en_q[g] && port_d_direction[g]) begin
               case (sel)
                  EDGE_RISE: ext_edge[g] = lvl_q & ~prev_q;
                  EDGE_FALL: ext_edge[g] = ~lvl_q & prev_q;
                  EDGE_BOTH: ext_edge[g] = lvl_q ^ prev_q;
                  default:   ext_edge[g] = 1'b0;
               endcase
            end
         end
      end
   endgenerate

   // ==========================================================
   // peripheral pin: sync and falling edge detect
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         per_sync_q <= '1;
      end else begin
         per_sync_q <= {per_sync_q[1:0], periph_irq_pin};
      end
   end
   assign per_fall = cfg_periph_pin_sel & per_sync_q[2] & ~per_sync_q[1];

   // pull-high selection passes through one register stage
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pull_q <= '0;
      end else begin
         pull_q <= port_pullup_sel;
      end
   end
   assign pullup_en = pull_q;

   // ==========================================================
   // source events
   always_comb begin
      mevt = '0;
      mevt[M_ADC] = src_evt.adc_done;
      mevt[M_RTC] = src_evt.rtc_ovf;
      mevt[M_TB]  = src_evt.tbase_ovf;
      mevt[M_PER] = per_fall;
      mevt[M_T2]  = src_evt.t2_ovf;
      evt = '0;
      evt[IX_EXT0]  = ext_edge[0];
      evt[IX_EXT1]  = ext_edge[1];
      evt[IX_T0]    = src_evt.t0_ovf;
      evt[IX_T1]    = src_evt.t1_ovf;
      evt[IX_SER]   = src_evt.serial_done;
      evt[IX_MULTI] = |(mevt & men_q);
   end

   // ==========================================================
   // arbitration on the second phase clock pulse
   assign pend  = flags_q & en_q;
   assign grant = first_set(pend);
   assign take  = core_in.second_phase_clock & gie_q
                & ~core_in.stack_full & (|pend);

   // ==========================================================
   // avalon-mm slave: one wait cycle on every access
   assign acc            = av.read | av.write;
   assign av_waitrequest = acc & (bus_q == BUS_IDLE);
   assign wr_ok = av.write & (bus_q == BUS_ACK);
   assign wr0   = wr_ok & (av.address == OFS_CTRL0) & av.byteenable[0];
   assign wr1   = wr_ok & (av.address == OFS_CTRL1) & av.byteenable[0];
   assign wr_m  = wr_ok & (av.address == OFS_MULTI);
   assign wr_e  = wr_ok & (av.address == OFS_EDGE) & av.byteenable[0];

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bus_q <= BUS_IDLE;
      end else begin
         case (bus_q)
            BUS_IDLE: bus_q <= acc ? BUS_ACK : BUS_IDLE;
            BUS_ACK:  bus_q <= BUS_IDLE;
            default:  bus_q <= BUS_IDLE;
         endcase
      end
   end

   // read data latched in the wait cycle, unmapped reads give zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (av.read && bus_q == BUS_IDLE) begin
         case (av.address)
            OFS_CTRL0:  rdata_q <= {25'h0000000, en_q, gie_q};
            OFS_CTRL1:  rdata_q <= {26'h0000000, flags_q};
            OFS_MULTI:  rdata_q <= {19'h00000, mflag_q, 3'h0, men_q};
            OFS_EDGE:   rdata_q <= {28'h0000000, edge_q};
            OFS_STATUS: rdata_q <= {11'h000, last_vec_q, 6'h00,
                                    cout_q.take, core_in.stack_full};
            default:    rdata_q <= '0;
         endcase
      end
   end
   assign av_readdata = rdata_q;

   // ==========================================================
   // global enable: cleared on entry, software write wins after
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gie_q <= 1'b0;
      end else if (wr0) begin
         gie_q <= av.writedata[F_GIE];
      end else if (take) begin
         gie_q <= 1'b0;
      end
   end

   // enables and edge selection
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         en_q   <= '0;
         men_q  <= '0;
         edge_q <= {EDGE_OFF, EDGE_OFF};
      end else begin
         if (wr0) begin
            en_q <= av.writedata[F_EN_LSB +: N_SRC];
         end
         if (wr_m && av.byteenable[0]) begin
            men_q <= av.writedata[N_MEM-1:0];
         end
         if (wr_e) begin
            edge_q <= av.writedata[3:0];
         end
      end
   end

   // main flags: write, then service clear, then events win
   assign flags_base = wr1 ? av.writedata[N_SRC-1:0] : flags_q;
   assign svc_clr    = take ? N_SRC'(1'b1) << grant : '0;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_base & ~svc_clr) | evt;
      end
   end

   // member flags are never cleared by service
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mflag_q <= '0;
      end else if (wr_m && av.byteenable[1]) begin
         mflag_q <= av.writedata[F_MFL_LSB +: N_MEM] | mevt;
      end else begin
         mflag_q <= mflag_q | mevt;
      end
   end

   // ==========================================================
   // core side: push, vector load and pop, all registered
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cout_q     <= '0;
         last_vec_q <= '0;
      end else begin
         cout_q.take <= take;
         cout_q.push <= take;
         cout_q.pop  <= core_in.return_from_interrupt;
         if (take) begin
            cout_q.push_pc <= core_in.next_pc;
            cout_q.vector  <= vec_of(grant);
            last_vec_q     <= vec_of(grant);
         end
      end
   end
   assign core_out = cout_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   gie_block_a: assert property (cout_q.take |-> $past(gie_q))
      else $error("interrupt taken with global enable clear");
   stack_block_a: assert property (cout_q.take |-> !$past(core_in.stack_full))
      else $error("interrupt taken while stack full");
   phase_sample_a: assert property (
      cout_q.take |-> $past(core_in.second_phase_clock))
      else $error("interrupt taken off the phase pulse");
   gie_clear_a: assert property (take && !wr0 |=> !gie_q && cout_q.take)
      else $error("global enable not cleared on entry");
   vector_push_a: assert property (
      take |=> cout_q.push && cout_q.push_pc == $past(core_in.next_pc)
      && cout_q.vector == vec_of($past(grant)))
      else $error("push or vector wrong on entry");
   prio_order_a: assert property (
      take && pend[IX_EXT0] |=> cout_q.vector == VEC_EXT0)
      else $error("highest priority source not granted");
   enable_gate_a: assert property (
      take |-> en_q[grant] && flags_q[grant])
      else $error("disabled request granted");
   return_from_interrupt_pop_a: assert property (
      core_in.return_from_interrupt |=> cout_q.pop ##1 !cout_q.pop
      || $past(core_in.return_from_interrupt))
      else $error("pop missing after return");
   flag_hold_a: assert property (evt[IX_T0] |=> flags_q[IX_T0])
      else $error("event lost against clear");
   multi_keep_a: assert property (
      take && grant == IX_MULTI && !wr_m |=> (mflag_q & $past(mflag_q)) == $past(mflag_q))
      else $error("member flags cleared by service");
   bus_wait_a: assert property (acc && av_waitrequest |=> !av_waitrequest)
      else $error("waitrequest held too long");
   ext_clear_a: assert property (
      take && grant == IX_EXT0 && !evt[IX_EXT0] && !wr1 |=> !flags_q[IX_EXT0])
      else $error("line flag not cleared on service");
   flag_keep_a: assert property (
      !gie_q && flags_q[IX_T1] && !wr1 |=> flags_q[IX_T1])
      else $error("pending flag lost while disabled");

   take_multi_c: cover property (take && grant == IX_MULTI);
   take_ext0_c: cover property (take && grant == IX_EXT0);
   stack_wait_c: cover property (core_in.second_phase_clock && gie_q
                                 && |pend && core_in.stack_full);
   nest_c: cover property (cout_q.take ##[1:20] wr0 && av.writedata[F_GIE]);
endmodule
